/* File: shared/pcs_pkg.sv */
// constants for the pll and system clock select block
package pcs_pkg;
    // ======================================================
    // register word offsets (byte addresses)
    localparam logic [7:0] PCS_OFF_PLL_SELECT_CONFIG = 8'h00;
    localparam logic [7:0] PCS_OFF_SYSTEM_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] PCS_OFF_SYSTEM_CONTROL_REG = 8'h08;
    localparam logic [7:0] PCS_OFF_OSCILLATOR_CONTROL_REG = 8'h0c;
    // ======================================================
    // pll_select_config fields
    localparam int PCS_RS_LSB = 12;
    localparam int PCS_IS_LSB = 9;
    localparam int PCS_C2S_BIT = 8;
    localparam int PCS_ND_LSB = 3;
    localparam int PCS_FIX_LSB = 1;
    localparam int PCS_PLLSEL_BIT = 0;
    localparam logic [3:0] PCS_RS_RESET = 4'h7;
    localparam logic [1:0] PCS_IS_RESET = 2'h1;
    localparam logic PCS_C2S_RESET = 1'b0;
    localparam logic [4:0] PCS_ND_RESET = 5'h03;
    localparam logic [1:0] PCS_FIX_RESET = 2'h3;
    localparam logic [3:0] PCS_RS_X8 = 4'ha;
    localparam logic [1:0] PCS_IS_X8 = 2'h0;
    localparam logic [4:0] PCS_ND_X8 = 5'h07;
    // ======================================================
    // system_clock_select fields
    localparam int PCS_SYSCK_BIT = 1;
    localparam int PCS_SYSFLG_BIT = 0;
    // ======================================================
    // system_control_reg fields
    localparam int PCS_GEAR_LSB = 0;
    localparam int PCS_PERIPH_SEL_BIT = 4;
    localparam int PCS_PRESC_SEL_BIT = 5;
    localparam int PCS_PRESC_DIV_LSB = 8;
    localparam logic [1:0] PCS_GEAR_RESET = 2'h0;
    localparam logic [2:0] PCS_PRESC_DIV_RESET = 3'h0;
    // ======================================================
    // oscillator_control_reg fields
    localparam int PCS_WUP_START_BIT = 0;
    localparam int PCS_WUP_BUSY_BIT = 1;
    localparam int PCS_WUP_CLK_SEL_BIT = 2;
    localparam int PCS_PLL_RUN_BIT = 3;
    localparam int PCS_WUP_COUNT_LSB = 20;
    localparam logic [11:0] PCS_WUP_COUNT_RESET = 12'h000;
    // ======================================================
    // clock switch states, gray from idle through drain to catch; catch back to idle flips both bits
    typedef enum logic [1:0] {
        PCS_SW_IDLE = 2'b00,
        PCS_SW_DRAIN = 2'b01,
        PCS_SW_CATCH = 2'b11
    } pcs_sw_state_t;
endpackage

/* File: design/pcs_glitch_switch.sv */
// glitch free switch between two clock tick streams
`timescale 1ns/1ps
module pcs_glitch_switch
    import pcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // sources and selection
    input wire logic tick_a,
    input wire logic tick_b,
    input wire logic sel,
    // result
    output logic tick_out,
    output logic cur
);
    pcs_sw_state_t state;
    pcs_sw_state_t next_state;
    logic old_tick;
    logic new_tick;

    assign old_tick = cur ? tick_b : tick_a;
    assign new_tick = cur ? tick_a : tick_b;
    // output muted while the switch is under way
    assign tick_out = (state == PCS_SW_IDLE) && old_tick;

    always_comb begin
        next_state = state;
        case (state)
            PCS_SW_IDLE: begin
                if (sel != cur) begin
                    next_state = PCS_SW_DRAIN;
                end
            end
            PCS_SW_DRAIN: begin
                if (old_tick) begin
                    next_state = PCS_SW_CATCH;
                end
            end
            PCS_SW_CATCH: begin
                if (new_tick) begin
                    next_state = PCS_SW_IDLE;
                end
            end
            default: next_state = PCS_SW_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= PCS_SW_IDLE;
            cur <= 1'b0;
        end else begin
            state <= next_state;
            if (state == PCS_SW_CATCH && new_tick) begin
                cur <= ~cur;
            end
        end
    end

    // ======================================================
    // checks
    switch_mute_a: assert property (@(posedge clk) disable iff (!rstn)
        (state != PCS_SW_IDLE) |-> !tick_out)
        else $error("tick passed during a clock switch");
    status_lag_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(cur) |-> $past(state) == PCS_SW_CATCH && $past(new_tick))
        else $error("switch status moved without both sources seen");
endmodule

/* File: design/pcs_warmup.sv */
// warm-up timer counting the selected oscillator ticks
`timescale 1ns/1ps
module pcs_warmup
    import pcs_pkg::*;
#(
    parameter int CW = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic start,
    input wire logic clk_sel,
    input wire logic tick_osc,
    input wire logic tick_ls,
    input wire logic [CW-1:0] limit,
    // status
    output logic busy
);
    logic [CW-1:0] count;
    logic tick;

    assign tick = clk_sel ? tick_ls : tick_osc;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
            busy <= 1'b0;
        end else if (start) begin
            count <= '0;
            busy <= 1'b1;
        end else if (busy && tick) begin
            count <= count + 1'b1;
            if (count + 1'b1 >= limit) begin
                busy <= 1'b0;
            end
        end
    end

    // ======================================================
    // checks
    busy_start_a: assert property (@(posedge clk) disable iff (!rstn)
        start |=> busy)
        else $error("warm-up did not start");
    busy_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (busy && !tick && !start) |=> busy)
        else $error("warm-up ended without a counted tick");
endmodule

/* File: design/pcs_clock_select.sv */
// pll and system clock select: registers, muxes, dividers, warm-up
//
// Contract
// - pll select bit routes oscillator (0) or pll (1) to high-speed clock.
// - system clock select bit picks gear clock (0) or low-speed clock (1).
// - read-only status shows the source driving system clock, after a lag.
// - gear clock is high-speed clock divided by 1, 2, 4 or 8.
// - prescaler clock is low-speed clock or peripheral clock over 2 to 32.
// - reset returns every derived clock except low-speed to the oscillator; the prescaler clock resets to the oscillator over 2.
// - pll output is four or eight times the oscillator per the multiplier.
// - a warm-up timer gives oscillator and pll a stabilisation interval.
// - warm-up counter counts the clock picked by the warm-up clock select.
// - writing 1 starts warm-up, reads 0; status is 1 while warm-up runs.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
module pcs_clock_select
    import pcs_pkg::*;
#(
    parameter int WUP_BITS = 16
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // register port
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // raw clock levels from the oscillators and the pll
    input wire logic OSC_CLK_IN,
    input wire logic LS_CLK_IN,
    input wire logic PLL_CLK_IN,
    // pll control
    output logic PLL_RUN,
    output logic PLL_MULT8,
    // derived clock ticks
    output logic HS_TICK,
    output logic GEAR_TICK,
    output logic PERIPH_TICK,
    output logic PRESC_TICK,
    output logic SYS_TICK
);
    // ======================================================
    // divider mask: low n bits set
    function automatic logic [4:0] pcs_mask(input logic [2:0] n);
        logic [4:0] m;
        m = 5'h00;
        for (int i = 0; i < 5; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // ======================================================
    // input synchronisers and edge ticks
    logic [2:0] raw_in;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] rise;
    assign raw_in = {PLL_CLK_IN, LS_CLK_IN, OSC_CLK_IN};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_sync
            always_ff @(posedge CLK or negedge RSTN) begin
                if (!RSTN) begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    sync3[g] <= 1'b0;
                end else begin
                    sync1[g] <= raw_in[g];
                    sync2[g] <= sync1[g];
                    sync3[g] <= sync2[g];
                end
            end
            assign rise[g] = sync2[g] & ~sync3[g];
        end
    endgenerate

    logic osc_tick;
    logic ls_tick;
    logic pll_tick;
    assign osc_tick = rise[0];
    assign ls_tick = rise[1];
    assign pll_tick = rise[2];

    // ======================================================
    // registers
    logic [3:0] pll_range_code;
    logic [1:0] pll_input_scale;
    logic pll_mult_bit;
    logic [4:0] pll_feedback_divider;
    logic [1:0] pll_fixed;
    logic pll_select;
    logic sys_select;
    logic [1:0] gear_select;
    logic peripheral_source_select;
    logic prescaler_source_select;
    logic [2:0] presc_div;
    logic wup_clk_sel;
    logic pll_run_enable;
    logic [11:0] wup_count;

    logic wr_pll;
    logic wr_sys;
    logic wr_ctl;
    logic wr_osc;
    logic wup_start;
    assign wr_pll = WR && ADDR == PCS_OFF_PLL_SELECT_CONFIG;
    assign wr_sys = WR && ADDR == PCS_OFF_SYSTEM_CLOCK_SELECT;
    assign wr_ctl = WR && ADDR == PCS_OFF_SYSTEM_CONTROL_REG;
    assign wr_osc = WR && ADDR == PCS_OFF_OSCILLATOR_CONTROL_REG;
    assign wup_start = wr_osc && WDATA[PCS_WUP_START_BIT];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            pll_range_code <= PCS_RS_RESET;
            pll_input_scale <= PCS_IS_RESET;
            pll_mult_bit <= PCS_C2S_RESET;
            pll_feedback_divider <= PCS_ND_RESET;
            pll_fixed <= PCS_FIX_RESET;
            pll_select <= 1'b0;
            sys_select <= 1'b0;
            gear_select <= PCS_GEAR_RESET;
            peripheral_source_select <= 1'b0;
            prescaler_source_select <= 1'b0;
            presc_div <= PCS_PRESC_DIV_RESET;
            wup_clk_sel <= 1'b0;
            pll_run_enable <= 1'b0;
            wup_count <= PCS_WUP_COUNT_RESET;
        end else begin
            if (wr_pll) begin
                pll_range_code <= WDATA[PCS_RS_LSB +: 4];
                pll_input_scale <= WDATA[PCS_IS_LSB +: 2];
                pll_mult_bit <= WDATA[PCS_C2S_BIT];
                pll_feedback_divider <= WDATA[PCS_ND_LSB +: 5];
                pll_fixed <= WDATA[PCS_FIX_LSB +: 2];
                pll_select <= WDATA[PCS_PLLSEL_BIT];
            end
            if (wr_sys) begin
                sys_select <= WDATA[PCS_SYSCK_BIT];
            end
            if (wr_ctl) begin
                gear_select <= WDATA[PCS_GEAR_LSB +: 2];
                peripheral_source_select <= WDATA[PCS_PERIPH_SEL_BIT];
                prescaler_source_select <= WDATA[PCS_PRESC_SEL_BIT];
                presc_div <= WDATA[PCS_PRESC_DIV_LSB +: 3];
            end
            if (wr_osc) begin
                wup_clk_sel <= WDATA[PCS_WUP_CLK_SEL_BIT];
                pll_run_enable <= WDATA[PCS_PLL_RUN_BIT];
                wup_count <= WDATA[PCS_WUP_COUNT_LSB +: 12];
            end
        end
    end

    // ======================================================
    // high-speed clock: oscillator or pll, glitch free
    logic hs_tick;
    logic hs_cur;
    pcs_glitch_switch u_hs_switch (
        .clk(CLK),
        .rstn(RSTN),
        .tick_a(osc_tick),
        .tick_b(pll_tick),
        .sel(pll_select),
        .tick_out(hs_tick),
        .cur(hs_cur)
    );

    // ======================================================
    // gear divider
    logic [2:0] gear_cnt;
    logic gear_tick;
    logic [4:0] gear_mask;
    assign gear_mask = pcs_mask({1'b0, gear_select});
    assign gear_tick = hs_tick && (gear_cnt & gear_mask[2:0]) == 3'h0;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gear_cnt <= 3'h0;
        end else if (hs_tick) begin
            gear_cnt <= gear_cnt + 3'h1;
        end
    end

    // ======================================================
    // peripheral and prescaler clocks
    logic periph_tick;
    logic [4:0] presc_cnt;
    logic [4:0] presc_mask;
    logic presc_div_tick;
    logic presc_tick;
    logic [2:0] presc_n;
    assign periph_tick = peripheral_source_select ? hs_tick : gear_tick;
    assign presc_n = (presc_div > 3'h4) ? 3'h5 : presc_div + 3'h1;
    assign presc_mask = pcs_mask(presc_n);
    assign presc_div_tick = periph_tick && (presc_cnt & presc_mask) == presc_mask;
    assign presc_tick = prescaler_source_select ? ls_tick : presc_div_tick;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            presc_cnt <= 5'h00;
        end else if (periph_tick) begin
            presc_cnt <= presc_cnt + 5'h01;
        end
    end

    // ======================================================
    // system clock: gear or low-speed, glitch free
    logic sys_tick;
    logic sys_cur;
    pcs_glitch_switch u_sys_switch (
        .clk(CLK),
        .rstn(RSTN),
        .tick_a(gear_tick),
        .tick_b(ls_tick),
        .sel(sys_select),
        .tick_out(sys_tick),
        .cur(sys_cur)
    );

    // ======================================================
    // warm-up timer
    logic wup_busy;
    pcs_warmup #(
        .CW(WUP_BITS)
    ) u_warmup (
        .clk(CLK),
        .rstn(RSTN),
        .start(wup_start),
        .clk_sel(wup_clk_sel),
        .tick_osc(osc_tick),
        .tick_ls(ls_tick),
        .limit(WUP_BITS'({wup_count, 4'h0})),
        .busy(wup_busy)
    );

    // ======================================================
    // multiplier decode
    logic mult8;
    assign mult8 = pll_range_code == PCS_RS_X8 && pll_input_scale == PCS_IS_X8
        && pll_feedback_divider == PCS_ND_X8;

    // ======================================================
    // read data
    logic [31:0] rd_pll;
    logic [31:0] rd_sys;
    logic [31:0] rd_ctl;
    logic [31:0] rd_osc;
    logic [31:0] next_rdata;
    assign rd_pll = {16'h0000, pll_range_code, 1'b0, pll_input_scale, pll_mult_bit,
        pll_feedback_divider, pll_fixed, pll_select};
    assign rd_sys = {30'h0, sys_select, sys_cur};
    assign rd_ctl = {21'h0, presc_div, 2'h0, prescaler_source_select,
        peripheral_source_select, 2'h0, gear_select};
    assign rd_osc = {wup_count, 16'h0000, pll_run_enable, wup_clk_sel, wup_busy,
        1'b0};
    assign next_rdata = !RD ? 32'h0 :
        ADDR == PCS_OFF_PLL_SELECT_CONFIG ? rd_pll :
        ADDR == PCS_OFF_SYSTEM_CLOCK_SELECT ? rd_sys :
        ADDR == PCS_OFF_SYSTEM_CONTROL_REG ? rd_ctl :
        ADDR == PCS_OFF_OSCILLATOR_CONTROL_REG ? rd_osc : 32'h0;

    // ======================================================
    // output flops
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 32'h0;
            PLL_RUN <= 1'b0;
            PLL_MULT8 <= 1'b0;
            HS_TICK <= 1'b0;
            GEAR_TICK <= 1'b0;
            PERIPH_TICK <= 1'b0;
            PRESC_TICK <= 1'b0;
            SYS_TICK <= 1'b0;
        end else begin
            RDATA <= next_rdata;
            PLL_RUN <= pll_run_enable;
            PLL_MULT8 <= mult8;
            HS_TICK <= hs_tick;
            GEAR_TICK <= gear_tick;
            PERIPH_TICK <= periph_tick;
            PRESC_TICK <= presc_tick;
            SYS_TICK <= sys_tick;
        end
    end

    // ======================================================
    // checks
    hs_source_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (hs_tick && !hs_cur) |-> osc_tick)
        else $error("high-speed tick not from oscillator");
    sys_source_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (sys_tick && sys_cur) |-> ls_tick)
        else $error("system tick not from low-speed clock");
    gear_div_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (gear_select == 2'h3 && gear_tick) |-> gear_cnt[2:0] == 3'h0)
        else $error("gear divide by eight wrong");
    presc_div_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (!prescaler_source_select && presc_tick) |-> periph_tick && presc_cnt[0])
        else $error("prescaler tick off divided phase");
    start_reads_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (RD && ADDR == PCS_OFF_OSCILLATOR_CONTROL_REG) |=> RDATA[PCS_WUP_START_BIT] == 1'b0)
        else $error("warm-up start bit read back as one");
    flag_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
        (RD && ADDR == PCS_OFF_SYSTEM_CLOCK_SELECT) |=> RDATA[PCS_SYSFLG_BIT] == $past(sys_cur))
        else $error("status flag read wrong");
    mult_out_a: assert property (@(posedge CLK) disable iff (!RSTN)
        ##1 PLL_MULT8 == $past(mult8))
        else $error("multiplier output not from decode");
endmodule

/* File: sim/testbench.sv */
// self-checking testbench for the pll and system clock select block
`timescale 1ns/1ps
module testbench;
    import pcs_pkg::*;
    // ======================================================
    // clock, reset and ports
    localparam int WIN = 1600;
    localparam int LIMIT = 80000;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    logic OSC_CLK_IN = 1'b0;
    logic LS_CLK_IN = 1'b0;
    logic PLL_CLK_IN = 1'b0;
    logic PLL_RUN, PLL_MULT8, HS_TICK, GEAR_TICK, PERIPH_TICK, PRESC_TICK, SYS_TICK;
    logic [7:0] ph = 8'h00;
    logic [2:0] raw_q = 3'h0;
    int cnt[8];
    int d[8];
    int cyc = 0;
    int bad_count = 0;
    int n_tests = 0;
    logic [31:0] r;
    int n;
    int t0;
    int per;
    int dv;
    logic [31:0] q;
    int dv_tab[6] = '{0, 1, 2, 3, 4, 7};

    pcs_clock_select #(.WUP_BITS(16)) dut (
        .CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .OSC_CLK_IN(OSC_CLK_IN), .LS_CLK_IN(LS_CLK_IN),
        .PLL_CLK_IN(PLL_CLK_IN), .PLL_RUN(PLL_RUN), .PLL_MULT8(PLL_MULT8),
        .HS_TICK(HS_TICK), .GEAR_TICK(GEAR_TICK), .PERIPH_TICK(PERIPH_TICK),
        .PRESC_TICK(PRESC_TICK), .SYS_TICK(SYS_TICK)
    );

    always #2 CLK = ~CLK;

    // ======================================================
    // raw sources: oscillator period 8, pll period 4, low-speed period 32
    always @(posedge CLK) begin
        ph <= ph + 8'h01;
        OSC_CLK_IN <= ph[2];
        PLL_CLK_IN <= ph[1];
        LS_CLK_IN <= ph[4];
    end

    // counts: 0 osc, 1 pll, 2 ls, 3 hs, 4 gear, 5 periph, 6 presc, 7 sys
    always @(posedge CLK) begin
        raw_q <= {LS_CLK_IN, PLL_CLK_IN, OSC_CLK_IN};
        if (OSC_CLK_IN && !raw_q[0]) cnt[0]++;
        if (PLL_CLK_IN && !raw_q[1]) cnt[1]++;
        if (LS_CLK_IN && !raw_q[2]) cnt[2]++;
        if (HS_TICK === 1'b1) cnt[3]++;
        if (GEAR_TICK === 1'b1) cnt[4]++;
        if (PERIPH_TICK === 1'b1) cnt[5]++;
        if (PRESC_TICK === 1'b1) cnt[6]++;
        if (SYS_TICK === 1'b1) cnt[7]++;
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            final_report();
        end
    end

    // ======================================================
    // bus tasks and compares
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= v;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 v = RDATA;
    endtask

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_near(input string what, input int exp, input int got);
        n_tests++;
        if (got < exp - 1 || got > exp + 1) begin
            bad_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic measure();
        int s[8];
        s = cnt;
        repeat (100) @(posedge CLK);
        s = cnt;
        repeat (WIN) @(posedge CLK);
        foreach (d[i]) d[i] = cnt[i] - s[i];
    endtask

    task automatic poll_sys(input logic want);
        n = 0;
        do begin
            rd(PCS_OFF_SYSTEM_CLOCK_SELECT, r);
            n++;
        end while (r[0] !== want && n < 200);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check_resets();
        rd(PCS_OFF_PLL_SELECT_CONFIG, r);
        check_val("pll reg", 32'h0000721e, r);
        rd(PCS_OFF_SYSTEM_CLOCK_SELECT, r);
        check_val("sys reg", 32'h0, r);
        rd(PCS_OFF_SYSTEM_CONTROL_REG, r);
        check_val("ctrl reg", 32'h0, r);
        rd(PCS_OFF_OSCILLATOR_CONTROL_REG, r);
        check_val("osc reg", 32'h0, r);
        check_val("pll flags", 32'h0, {30'h0, PLL_RUN, PLL_MULT8});
        measure();
        check_near("hs eq osc", d[0], d[3]);
        check_near("gear eq osc", d[0], d[4]);
        check_near("sys eq osc", d[0], d[7]);
    endtask

    // ======================================================
    // main sequence
    initial begin
        void'($urandom(70751));
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        check_resets();
        $display("test reset done");

        // gear division by 1, 2, 4, 8
        for (int g = 0; g < 4; g++) begin
            wr(PCS_OFF_SYSTEM_CONTROL_REG, g);
            measure();
            check_near("gear ticks", d[3] / (1 << g), d[4]);
        end
        // prescaler division, codes above 4 stay at 32
        foreach (dv_tab[k]) begin
            wr(PCS_OFF_SYSTEM_CONTROL_REG, dv_tab[k] << 8);
            dv = (dv_tab[k] > 4) ? 32 : (2 << dv_tab[k]);
            measure();
            check_near("presc ticks", d[5] / dv, d[6]);
        end
        wr(PCS_OFF_SYSTEM_CONTROL_REG, 32'h13);
        measure();
        check_near("periph hs", d[3], d[5]);
        check_near("gear div8", d[3] / 8, d[4]);
        wr(PCS_OFF_SYSTEM_CONTROL_REG, 32'h20);
        measure();
        check_near("presc ls", d[2], d[6]);
        $display("test dividers done");

        // system clock switch both ways
        wr(PCS_OFF_SYSTEM_CLOCK_SELECT, 32'h2);
        rd(PCS_OFF_SYSTEM_CLOCK_SELECT, r);
        check_val("sys select", 32'h1, {31'h0, r[1]});
        poll_sys(1'b1);
        check_val("sys status ls", 32'h3, r);
        measure();
        check_near("sys ls", d[2], d[7]);
        wr(PCS_OFF_SYSTEM_CLOCK_SELECT, 32'hffff_fffd);
        poll_sys(1'b0);
        check_val("sys status gear", 32'h0, r);
        measure();
        check_near("sys gear", d[4], d[7]);
        $display("test switch done");

        // pll multiplier, run and select
        wr(PCS_OFF_PLL_SELECT_CONFIG, 32'h0000a03e);
        rd(PCS_OFF_PLL_SELECT_CONFIG, r);
        check_val("pll 8x", 32'h0000a03e, r);
        check_val("mult8", 32'h1, {31'h0, PLL_MULT8});
        // pll held stopped a little over 100 us before it runs
        repeat (25001) @(posedge CLK);
        wr(PCS_OFF_OSCILLATOR_CONTROL_REG, 32'h8);
        repeat (2) @(posedge CLK);
        check_val("pll run", 32'h1, {31'h0, PLL_RUN});
        wr(PCS_OFF_PLL_SELECT_CONFIG, 32'hffff_a03f);
        measure();
        check_near("hs eq pll", d[1], d[3]);
        wr(PCS_OFF_OSCILLATOR_CONTROL_REG, 32'h0);
        wr(PCS_OFF_PLL_SELECT_CONFIG, 32'h0000721e);
        repeat (2) @(posedge CLK);
        check_val("mult4", 32'h0, {31'h0, PLL_MULT8});
        measure();
        check_near("hs back osc", d[0], d[3]);
        $display("test pll done");

        // warm-up on each counting clock, count of 16 ticks
        for (int s = 0; s < 2; s++) begin
            per = s ? 32 : 8;
            wr(PCS_OFF_OSCILLATOR_CONTROL_REG, 32'h00100001 | (s << 2));
            t0 = cyc;
            rd(PCS_OFF_OSCILLATOR_CONTROL_REG, r);
            check_val("wup busy", 32'h00100002 | (s << 2), r);
            n = 0;
            do begin
                rd(PCS_OFF_OSCILLATOR_CONTROL_REG, r);
                n++;
            end while (r[1] !== 1'b0 && n < 400);
            check_val("wup done", 32'h00100000 | (s << 2), r);
            n = cyc - t0;
            check_val("wup span", 32'h1, {31'h0, n >= 15 * per && n <= 18 * per + 20});
        end
        $display("test warmup done");

        // random register traffic with unmapped places
        repeat (24) begin
            r = $urandom();
            if ($urandom() % 2) begin
                wr(PCS_OFF_SYSTEM_CONTROL_REG, r);
                wr(8'h10 + 8'(($urandom() % 60) * 4), ~r);
                rd(PCS_OFF_SYSTEM_CONTROL_REG, q);
                check_val("ctrl rw", r & 32'h00000733, q);
            end else begin
                wr(PCS_OFF_OSCILLATOR_CONTROL_REG, r & 32'hfffffff6);
                rd(PCS_OFF_OSCILLATOR_CONTROL_REG, q);
                check_val("osc rw", r & 32'hfff00004, q);
            end
            rd(8'h10 + 8'(($urandom() % 60) * 4), q);
            check_val("unmapped", 32'h0, q);
        end
        $display("test random done");

        // reset in mid-run
        wr(PCS_OFF_SYSTEM_CLOCK_SELECT, 32'h2);
        wr(PCS_OFF_PLL_SELECT_CONFIG, 32'h0000721f);
        @(posedge CLK);
        RSTN <= 1'b0;
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        check_resets();
        $display("test rereset done");
        final_report();
    end
endmodule
